// File: design/bert_status_interrupt.v
// Status register, interrupt enable register and interrupt pin of the tester.
// Holds the latched event flags and their clear-on-read behaviour.
// Assumes receive events arrive as mclk-synchronous pulses and levels from the
// receiver, and a single-cycle register port strobe from the parallel port logic.
`timescale 1ns/1ps
`include "bert_status_defines.vh"

// Notes on behaviour
// - Status byte at 0x14, bits 6..0 defined
// - Enable byte at 0x15 matches status bits
// - Enable zero masks, one passes event
// - Loss-of-lock set while hunting for sync
// - Loss-of-lock stays set until read
// - Received counter wrap sets overflow flag
// - Read clears error and overflow flags
// - Read clears condition flags only when ended
// - Interrupt low while enabled flag set
module bert_status_interrupt (
  input wire mclk,
  input wire srst,
  input wire rx_bit_valid,
  input wire rx_bit,
  input wire in_sync,
  input wire bit_error,
  input wire received_bit_counter_wrap,
  input wire error_bit_counter_wrap,
  input wire reg_sel,
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output wire int_n,
  output wire int_oe
);

  // ----------------------------------------
  // Run detection of identical bits
  // ----------------------------------------
  reg [`RUN_WIDTH-1:0] ones_run;
  reg [`RUN_WIDTH-1:0] zeros_run;
  reg [`RUN_WIDTH-1:0] next_ones_run;
  reg [`RUN_WIDTH-1:0] next_zeros_run;
  wire ones_cond;
  wire zeros_cond;

  assign ones_cond = (ones_run == `RUN_LENGTH);
  assign zeros_cond = (zeros_run == `RUN_LENGTH);

  always @* begin
    next_ones_run = ones_run;
    next_zeros_run = zeros_run;
    if (rx_bit_valid) begin
      if (rx_bit) begin
        next_zeros_run = 6'h00;
        // Saturate so that a long run keeps its condition
        if (!ones_cond) begin
          next_ones_run = ones_run + 6'h01;
        end
      end else begin
        next_ones_run = 6'h00;
        if (!zeros_cond) begin
          next_zeros_run = zeros_run + 6'h01;
        end
      end
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      ones_run <= 6'h00;
      zeros_run <= 6'h00;
    end else begin
      ones_run <= next_ones_run;
      zeros_run <= next_zeros_run;
    end
  end

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  reg [7:0] event_interrupt_enable;
  reg [7:0] next_rdata;
  wire reg_read;
  wire enable_write;
  wire status_read;

  assign reg_read = reg_sel && !reg_write;
  assign enable_write = reg_sel && reg_write && (reg_addr == `ADDR_EVENT_INTERRUPT_ENABLE);
  assign status_read = reg_read && (reg_addr == `ADDR_EVENT_STATUS);

  // Enable byte write, top bit stored as zero
  always @(posedge mclk) begin
    if (srst) begin
      event_interrupt_enable <= `EVENT_ENABLE_RESET;
    end else if (enable_write) begin
      event_interrupt_enable <= reg_wdata & `EVENT_ENABLE_MASK;
    end
  end

  // ----------------------------------------
  // Latched flags
  // ----------------------------------------
  wire hunting;
  wire all_ones_seen;
  wire all_zeros_seen;
  wire loss_of_lock_flag;
  wire error_detected_flag;
  wire received_count_overflow;
  wire error_count_overflow;

  assign hunting = !in_sync;

  sticky_flag u_all_ones (
    .mclk(mclk),
    .srst(srst),
    .set_event(1'b0),
    .condition_active(ones_cond),
    .read_clear(status_read),
    .flag(all_ones_seen)
  );

  sticky_flag u_all_zeros (
    .mclk(mclk),
    .srst(srst),
    .set_event(1'b0),
    .condition_active(zeros_cond),
    .read_clear(status_read),
    .flag(all_zeros_seen)
  );

  sticky_flag u_loss_of_lock (
    .mclk(mclk),
    .srst(srst),
    .set_event(1'b0),
    .condition_active(hunting),
    .read_clear(status_read),
    .flag(loss_of_lock_flag)
  );

  sticky_flag u_error_detected (
    .mclk(mclk),
    .srst(srst),
    .set_event(bit_error),
    .condition_active(1'b0),
    .read_clear(status_read),
    .flag(error_detected_flag)
  );

  sticky_flag u_received_ovf (
    .mclk(mclk),
    .srst(srst),
    .set_event(received_bit_counter_wrap),
    .condition_active(1'b0),
    .read_clear(status_read),
    .flag(received_count_overflow)
  );

  sticky_flag u_error_ovf (
    .mclk(mclk),
    .srst(srst),
    .set_event(error_bit_counter_wrap),
    .condition_active(1'b0),
    .read_clear(status_read),
    .flag(error_count_overflow)
  );

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  wire [6:0] flags;
  wire [7:0] event_status;

  assign flags[`BIT_ALL_ONES] = all_ones_seen;
  assign flags[`BIT_ALL_ZEROS] = all_zeros_seen;
  assign flags[`BIT_LOSS_OF_LOCK] = loss_of_lock_flag;
  assign flags[`BIT_ERROR_DETECTED] = error_detected_flag;
  assign flags[`BIT_RECEIVED_OVF] = received_count_overflow;
  assign flags[`BIT_ERROR_OVF] = error_count_overflow;
  // Real-time sync is not latched
  assign flags[`BIT_SYNC] = in_sync;

  assign event_status = {1'b0, flags};

  // Read data decode
  always @* begin
    case (reg_addr)
      `ADDR_EVENT_STATUS: next_rdata = event_status;
      `ADDR_EVENT_INTERRUPT_ENABLE: next_rdata = event_interrupt_enable;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data stands until the next read
  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  wire [7:0] pending;

  assign pending = event_status & event_interrupt_enable;

  // Open-drain low while enabled flag set
  assign int_oe = |pending;
  assign int_n = 1'b0;

endmodule // bert_status_interrupt

// File: inc/bert_status_defines.vh
// Register map, field positions and reset values of the status and interrupt block.
// Assumes inclusion by bare name from design files.
`ifndef BERT_STATUS_DEFINES_VH
`define BERT_STATUS_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_EVENT_STATUS 8'h14
`define ADDR_EVENT_INTERRUPT_ENABLE 8'h15

// ----------------------------------------
// Status and enable bit positions
// ----------------------------------------
`define BIT_ALL_ONES 6
`define BIT_ALL_ZEROS 5
`define BIT_LOSS_OF_LOCK 4
`define BIT_ERROR_DETECTED 3
`define BIT_RECEIVED_OVF 2
`define BIT_ERROR_OVF 1
`define BIT_SYNC 0

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define EVENT_STATUS_RESET 8'h00
`define EVENT_ENABLE_RESET 8'h00
`define EVENT_ENABLE_MASK 8'h7F
`define RUN_LENGTH 6'h20
`define RUN_WIDTH 6

`endif

// File: design/sticky_flag.v
// One latched status flag with clear-on-read.
// Assumes set, condition and read strobe are all on mclk.
`timescale 1ns/1ps
module sticky_flag (
  input wire mclk,
  input wire srst,
  input wire set_event,
  input wire condition_active,
  input wire read_clear,
  output reg flag
);
  // Set wins over a clear; the clear only takes if the condition has ended
  always @(posedge mclk) begin
    if (srst) begin
      flag <= 1'b0;
    end else if (set_event || condition_active) begin
      flag <= 1'b1;
    end else if (read_clear) begin
      flag <= 1'b0;
    end
  end
endmodule // sticky_flag

// File: tb/bert_status_interrupt_asserts.sv
// Port checker of the status block; the bind at the foot attaches it to the block.
// Assumes every watched port is on mclk and srst is synchronous, active high.
`timescale 1ns/1ps
module bert_status_interrupt_asserts (
  input wire mclk,
  input wire srst,
  input wire in_sync,
  input wire bit_error,
  input wire reg_sel,
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire int_n,
  input wire int_oe
);
  reg [7:0] en;
  wire rd = reg_sel && !reg_write;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  always @(posedge mclk)
    en <= srst ? 8'h00 : (reg_sel && reg_write && reg_addr == 8'h15) ? reg_wdata & 8'h7F : en;
  chk_err_irq: assert property (bit_error && en[3] |=> int_oe) else $error("no irq");
  chk_los_irq: assert property (!in_sync ##1 !in_sync && en[4] |-> int_oe) else $error("no irq");
  chk_mask_off: assert property (en == 8'h00 |-> !int_oe) else $error("masked irq");
  chk_stat_top: assert property (rd && reg_addr == 8'h14 |=> !reg_rdata[7]) else $error("b7");
  chk_en_read: assert property (rd && reg_addr == 8'h15 |=> reg_rdata == $past(en)) else $error("en");
  chk_unmapped: assert property (rd && reg_addr > 8'h15 |=> reg_rdata == 8'h00) else $error("map");
  chk_rdata_hold: assert property (!rd |=> $stable(reg_rdata)) else $error("rdata moved");
  chk_pin_low: assert property (!int_n) else $error("pin level");
  cover property (bit_error && en[3]);
  cover property (!in_sync && en[4]);
  cover property (rd && reg_addr == 8'h14);
endmodule // bert_status_interrupt_asserts
bind bert_status_interrupt bert_status_interrupt_asserts u_chk (.mclk, .srst, .in_sync,
  .bit_error, .reg_sel, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .int_n, .int_oe);

// File: tb/host_model.sv
// Host processor on the register port; requests change at the falling edge of mclk.
// Assumes a one-cycle strobe and read data registered one edge after it.
`timescale 1ns/1ps
module host_model (
  input wire mclk,
  output reg reg_sel = 1'h0,
  output reg reg_write = 1'h0,
  output reg [7:0] reg_addr = 8'h00,
  output reg [7:0] reg_wdata = 8'h00,
  input wire [7:0] reg_rdata
);
  task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    @(negedge mclk) {reg_sel, reg_write, reg_addr, reg_wdata} = {1'h1, w, a, d & 8'h7F};
    @(negedge mclk) {reg_sel, reg_wdata} = {1'h0, ~reg_wdata};
    q = reg_rdata;
  endtask
endmodule // host_model

// File: tb/bert_status_interrupt_tb.sv
// Bench: host model on the register port, receiver events driven here.
// Assumes the checker is bound to the block from its own file.
`timescale 1ns/1ps
module bert_status_interrupt_tb;
  reg mclk = 1'h0, srst = 1'h1, in_sync = 1'h1;
  reg [4:0] drv = 5'h00;
  reg [7:0] v;
  wire reg_sel, reg_write, int_n, int_oe;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  integer n_errors = 0, n_checks = 0;
  always #20 mclk = ~mclk;
  host_model u_host_model (.mclk, .reg_sel, .reg_write, .reg_addr, .reg_wdata, .reg_rdata);
  bert_status_interrupt u_bert_status_interrupt (.mclk, .srst, .rx_bit_valid(drv[1]),
    .rx_bit(drv[0]), .in_sync, .bit_error(drv[4]), .received_bit_counter_wrap(drv[3]),
    .error_bit_counter_wrap(drv[2]), .reg_sel, .reg_write, .reg_addr, .reg_wdata,
    .reg_rdata, .int_n, .int_oe);
  task check(input [7:0] seen, input [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) n_errors = n_errors + 1;
    if (seen !== exp) $display("MISMATCH %0t %h %h", $time, seen, exp);
  endtask
  task ac(input w, input [7:0] a, input [7:0] d);
    u_host_model.xfer(w, a, d, v);
    if (!w) check(v, d);
  endtask
  task step(input [4:0] d, input integer n);
    repeat (n) @(negedge mclk) drv = d;
    @(negedge mclk) drv = 5'h00;
  endtask
  task t_events;
    check({6'h00, int_n, int_oe}, 8'h00);
    ac(1'h0, 8'h14, 8'h01);
    ac(1'h0, 8'h15, 8'h00);
    ac(1'h0, 8'h16, 8'h00);
    ac(1'h1, 8'h15, 8'hFF);
    ac(1'h0, 8'h15, 8'h7F);
    ac(1'h1, 8'h15, 8'h04);
    step(5'h10, 1);
    check({6'h00, int_n, int_oe}, 8'h00);
    ac(1'h1, 8'h15, 8'h1C);
    check({6'h00, int_n, int_oe}, 8'h01);
    step(5'h1C, 1);
    ac(1'h0, 8'h14, 8'h0F);
    check({6'h00, int_n, int_oe}, 8'h00);
  endtask
  task t_cond;
    in_sync = 1'h0;
    step(5'h00, 2);
    ac(1'h0, 8'h14, 8'h10);
    in_sync = 1'h1;
    ac(1'h0, 8'h14, 8'h11);
    step(5'h03, 31);
    step(5'h02, 32);
    ac(1'h0, 8'h14, 8'h21);
    step(5'h03, 32);
    ac(1'h0, 8'h14, 8'h61);
    ac(1'h0, 8'h14, 8'h41);
  endtask
  task t_reset;
    ac(1'h1, 8'h15, 8'h40);
    check({6'h00, int_n, int_oe}, 8'h01);
    srst = 1'h1;
    step(5'h00, 2);
    srst = 1'h0;
    check({6'h00, int_n, int_oe}, 8'h00);
    ac(1'h0, 8'h15, 8'h00);
    ac(1'h0, 8'h14, 8'h01);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk) srst = 1'h0;
    t_events;
    t_cond;
    t_reset;
    end_of_test;
  end
  initial begin
    #20000 n_errors = n_errors + 1;
    end_of_test;
  end
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
endmodule // bert_status_interrupt_tb
